// file: src/tsf_pkg.sv
package tsf_pkg;
	// ************************************************
	// sizes
	// ************************************************
	localparam int TSF_DEPTH = 32;
	localparam int TSF_IDX_W = 5;
	localparam int TSF_CNT_W = 6;
	localparam int TSF_WORD_W = 16;
	localparam int TSF_BYTE_W = 8;
	localparam int TSF_STAGE_DEPTH = 16;
	localparam logic [5:0] TSF_FULL_CNT = 6'h20;
	localparam logic [4:0] TSF_IDX_MAX = 5'h1F;
	localparam logic [4:0] TSF_IDX_ONE = 5'h01;
	localparam logic [5:0] TSF_CNT_ONE = 6'h01;
	// ************************************************
	// register offsets
	// ************************************************
	localparam logic [7:0] TSF_ADDR_STATUS = 8'h00;
	localparam logic [7:0] TSF_ADDR_WR_IDX = 8'h04;
	localparam logic [7:0] TSF_ADDR_RD_IDX = 8'h05;
	localparam logic [7:0] TSF_ADDR_LOST = 8'h06;
	localparam logic [7:0] TSF_ADDR_OCC = 8'h07;
	localparam logic [7:0] TSF_ADDR_POP = 8'h08;
	localparam logic [7:0] TSF_ADDR_WMARK = 8'h09;
	localparam logic [7:0] TSF_ADDR_POLICY = 8'h0A;
	// ************************************************
	// field positions and values
	// ************************************************
	localparam int TSF_STAT_AFULL_BIT = 7;
	localparam int TSF_POL_FLUSH_BIT = 4;
	localparam int TSF_POL_STATCLR_BIT = 3;
	localparam int TSF_POL_TYPE_BIT = 2;
	localparam int TSF_POL_ROLL_BIT = 1;
	localparam logic [1:0] TSF_PIN_IRQ_MODE = 2'h3;
	localparam logic [7:0] TSF_ZERO_BYTE = 8'h00;
	typedef enum logic {TSF_HIGH_BYTE, TSF_LOW_BYTE} tsf_phase_t;
endpackage : tsf_pkg

// file: src/tsf_sample_queue.sv
`timescale 1ns/1ps
// ************************************************
// staging fifo between conversion and queue
// ************************************************
module tsf_stage_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic in_valid_i,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic in_ready_o,
	output logic out_valid_o,
	output logic [WIDTH-1:0] out_data_o,
	input wire logic out_ready_i
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wp_reg, rp_reg;
	logic [AW:0] cnt_reg, cnt_next;
	logic do_in, do_out;
	assign do_in = in_valid_i && in_ready_o;
	assign do_out = out_valid_o && out_ready_i;
	assign out_data_o = mem[rp_reg];
	// count of held words
	always_comb begin
		cnt_next = cnt_reg;
		if (do_in && !do_out) begin
			cnt_next = cnt_reg + 1'b1;
		end else if (do_out && !do_in) begin
			cnt_next = cnt_reg - 1'b1;
		end
	end
	// pointers, count and registered flags
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wp_reg <= '0;
			rp_reg <= '0;
			cnt_reg <= '0;
			in_ready_o <= 1'b0;
			out_valid_o <= 1'b0;
		end else begin
			if (do_in) begin
				wp_reg <= AW'(wp_reg + 1'b1);
			end
			if (do_out) begin
				rp_reg <= AW'(rp_reg + 1'b1);
			end
			cnt_reg <= cnt_next;
			in_ready_o <= (cnt_next != (AW+1)'(DEPTH));
			out_valid_o <= (cnt_next != '0);
		end
	end
	// storage
	always_ff @(posedge clk_i) begin
		if (do_in) begin
			mem[wp_reg] <= in_data_i;
		end
	end
endmodule : tsf_stage_fifo

// ************************************************
// temperature sample queue
// ************************************************
module tsf_sample_queue (
	input wire logic SYS_CLK_I,
	input wire logic RST_B_I,
	input wire logic SAMPLE_VALID_I,
	input wire logic [tsf_pkg::TSF_WORD_W-1:0] SAMPLE_DATA_I,
	output logic SAMPLE_READY_O,
	input wire logic [7:0] REG_ADDR_I,
	input wire logic REG_RD_I,
	input wire logic REG_WR_I,
	input wire logic [7:0] REG_WDATA_I,
	output logic [7:0] REG_RDATA_O,
	input wire logic AFULL_IRQ_EN_I,
	input wire logic [1:0] PIN_ZERO_FUNCTION_I,
	output logic AFULL_FLAG_O,
	output logic GENERAL_PIN_ZERO_IRQ_O
);
	import tsf_pkg::*;
	logic [TSF_WORD_W-1:0] queue_mem [TSF_DEPTH];
	logic [4:0] write_index_reg, read_index_reg, lost_word_counter_reg;
	logic [4:0] watermark_reg;
	logic [5:0] occ_reg, occ_next, thresh;
	logic pop_clears_flag_reg, afull_type_reg, overwrite_when_full_reg;
	logic a_full_reg, cond_reg, cond_next;
	tsf_phase_t phase_reg;
	logic st_valid, st_ready, st_rdy_flop;
	logic [TSF_WORD_W-1:0] st_data;
	logic push, full_eff, store, flush, pop_rd, pop_adv, status_rd;
	logic set_flag, clr_flag;
	logic [7:0] rdata_next;

	// ************************************************
	// staging buffer
	// ************************************************
	tsf_stage_fifo #(.WIDTH(TSF_WORD_W), .DEPTH(TSF_STAGE_DEPTH)) u_stage (
		.clk_i(SYS_CLK_I),
		.rst_b_i(RST_B_I),
		.in_valid_i(SAMPLE_VALID_I),
		.in_data_i(SAMPLE_DATA_I),
		.in_ready_o(st_rdy_flop),
		.out_valid_o(st_valid),
		.out_data_o(st_data),
		.out_ready_i(st_ready)
	);
	assign SAMPLE_READY_O = st_rdy_flop; // flop inside stage fifo

	// ************************************************
	// event decode
	// ************************************************
	// queue drain stalls during any register access or flush
	assign flush = REG_WR_I && (REG_ADDR_I == TSF_ADDR_POLICY) && REG_WDATA_I[TSF_POL_FLUSH_BIT];
	assign st_ready = !flush && !REG_RD_I && !REG_WR_I;
	assign push = st_valid && st_ready;
	assign pop_rd = REG_RD_I && (REG_ADDR_I == TSF_ADDR_POP);
	assign pop_adv = pop_rd && (phase_reg == TSF_LOW_BYTE);
	assign status_rd = REG_RD_I && (REG_ADDR_I == TSF_ADDR_STATUS);
	assign full_eff = (occ_reg == TSF_FULL_CNT) && !pop_adv;
	assign store = push && (!full_eff || overwrite_when_full_reg);

	// ************************************************
	// storage
	// ************************************************
	// sample written at write index
	always_ff @(posedge SYS_CLK_I) begin
		if (store) begin
			queue_mem[write_index_reg] <= st_data;
		end
	end

	// write index
	always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			write_index_reg <= '0;
		end else if (flush) begin
			write_index_reg <= '0;
		end else if (store) begin
			write_index_reg <= write_index_reg + TSF_IDX_ONE;
		end
	end

	// read index, also pushed on by an overwrite
	always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			read_index_reg <= '0;
		end else if (flush) begin
			read_index_reg <= '0;
		end else if (REG_WR_I && (REG_ADDR_I == TSF_ADDR_RD_IDX)) begin
			read_index_reg <= REG_WDATA_I[TSF_IDX_W-1:0];
		end else if (pop_adv || (push && full_eff && overwrite_when_full_reg)) begin
			read_index_reg <= read_index_reg + TSF_IDX_ONE;
		end
	end

	// byte phase within a word
	always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			phase_reg <= TSF_HIGH_BYTE;
		end else if (flush || (REG_WR_I && (REG_ADDR_I == TSF_ADDR_RD_IDX))) begin
			phase_reg <= TSF_HIGH_BYTE;
		end else if (pop_rd) begin
			phase_reg <= (phase_reg == TSF_HIGH_BYTE) ? TSF_LOW_BYTE : TSF_HIGH_BYTE;
		end
	end

	// ************************************************
	// counters
	// ************************************************
	// occupancy next value
	always_comb begin
		occ_next = occ_reg;
		if (flush) begin
			occ_next = '0;
		end else if (push && !full_eff && !(pop_adv && occ_reg != '0)) begin
			occ_next = occ_reg + TSF_CNT_ONE;
		end else if (!(push && !full_eff) && pop_adv && occ_reg != '0) begin
			occ_next = occ_reg - TSF_CNT_ONE;
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			occ_reg <= '0;
		end else begin
			occ_reg <= occ_next;
		end
	end

	// lost words, a same-cycle pop clears the count, since full_eff is masked by pop_adv
	always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			lost_word_counter_reg <= '0;
		end else if (flush) begin
			lost_word_counter_reg <= '0;
		end else if (push && full_eff) begin
			if (lost_word_counter_reg != TSF_IDX_MAX) begin
				lost_word_counter_reg <= lost_word_counter_reg + TSF_IDX_ONE;
			end
		end else if (pop_adv) begin
			lost_word_counter_reg <= '0;
		end
	end

	// ************************************************
	// configuration
	// ************************************************
	// watermark and policy bits; flush bit is never stored
	always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			watermark_reg <= '0;
			pop_clears_flag_reg <= 1'b0;
			afull_type_reg <= 1'b0;
			overwrite_when_full_reg <= 1'b0;
		end else if (REG_WR_I) begin
			if (REG_ADDR_I == TSF_ADDR_WMARK) begin
				watermark_reg <= REG_WDATA_I[TSF_IDX_W-1:0];
			end else if (REG_ADDR_I == TSF_ADDR_POLICY) begin
				pop_clears_flag_reg <= REG_WDATA_I[TSF_POL_STATCLR_BIT];
				afull_type_reg <= REG_WDATA_I[TSF_POL_TYPE_BIT];
				overwrite_when_full_reg <= REG_WDATA_I[TSF_POL_ROLL_BIT];
			end
		end
	end

	// ************************************************
	// almost-full flag
	// ************************************************
	assign thresh = TSF_FULL_CNT - {1'b0, watermark_reg};
	assign cond_next = (occ_next >= thresh);
	assign set_flag = push && !flush && cond_next && (!afull_type_reg || !cond_reg);
	assign clr_flag = status_rd || (pop_rd && pop_clears_flag_reg);

	// set wins over clear
	always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			a_full_reg <= 1'b0;
			cond_reg <= 1'b0;
		end else begin
			cond_reg <= cond_next;
			if (set_flag) begin
				a_full_reg <= 1'b1;
			end else if (clr_flag) begin
				a_full_reg <= 1'b0;
			end
		end
	end
	assign AFULL_FLAG_O = a_full_reg;

	// pin zero interrupt level
	always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			GENERAL_PIN_ZERO_IRQ_O <= 1'b0;
		end else begin
			GENERAL_PIN_ZERO_IRQ_O <= a_full_reg && AFULL_IRQ_EN_I &&
				(PIN_ZERO_FUNCTION_I == TSF_PIN_IRQ_MODE);
		end
	end

	// ************************************************
	// read data
	// ************************************************
	always_comb begin
		rdata_next = TSF_ZERO_BYTE;
		if (REG_ADDR_I == TSF_ADDR_STATUS) begin
			rdata_next[TSF_STAT_AFULL_BIT] = a_full_reg;
		end else if (REG_ADDR_I == TSF_ADDR_WR_IDX) begin
			rdata_next[TSF_IDX_W-1:0] = write_index_reg;
		end else if (REG_ADDR_I == TSF_ADDR_RD_IDX) begin
			rdata_next[TSF_IDX_W-1:0] = read_index_reg;
		end else if (REG_ADDR_I == TSF_ADDR_LOST) begin
			rdata_next[TSF_IDX_W-1:0] = lost_word_counter_reg;
		end else if (REG_ADDR_I == TSF_ADDR_OCC) begin
			rdata_next[TSF_CNT_W-1:0] = occ_reg;
		end else if (REG_ADDR_I == TSF_ADDR_POP) begin
			if (phase_reg == TSF_HIGH_BYTE) begin
				rdata_next = queue_mem[read_index_reg][TSF_WORD_W-1:TSF_BYTE_W];
			end else begin
				rdata_next = queue_mem[read_index_reg][TSF_BYTE_W-1:0];
			end
		end else if (REG_ADDR_I == TSF_ADDR_WMARK) begin
			rdata_next[TSF_IDX_W-1:0] = watermark_reg;
		end else if (REG_ADDR_I == TSF_ADDR_POLICY) begin
			rdata_next[TSF_POL_STATCLR_BIT] = pop_clears_flag_reg;
			rdata_next[TSF_POL_TYPE_BIT] = afull_type_reg;
			rdata_next[TSF_POL_ROLL_BIT] = overwrite_when_full_reg;
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			REG_RDATA_O <= TSF_ZERO_BYTE;
		end else if (REG_RD_I) begin
			REG_RDATA_O <= rdata_next;
		end
	end

	// ************************************************
	// assertions
	// ************************************************
	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (!RST_B_I);

	a_flush_empties: assert property (flush |=> occ_reg == '0 && write_index_reg == '0 &&
		read_index_reg == '0 && lost_word_counter_reg == '0) else $error("flush left state");
	a_pop_two_bytes: assert property (pop_rd && phase_reg == TSF_HIGH_BYTE ##1
		pop_rd && !flush && !push |=> read_index_reg == $past(read_index_reg) + TSF_IDX_ONE)
		else $error("word pop did not advance read index");
	a_lost_clear_pop: assert property (pop_adv && !flush && !(push && full_eff) |=>
		lost_word_counter_reg == '0) else $error("lost counter not cleared");
	a_lost_saturates: assert property (push && full_eff && !flush |=>
		lost_word_counter_reg == (($past(lost_word_counter_reg) == TSF_IDX_MAX) ?
		TSF_IDX_MAX : $past(lost_word_counter_reg) + TSF_IDX_ONE)) else $error("lost count wrong");
	a_drop_keeps_queue: assert property (push && full_eff && !overwrite_when_full_reg && !flush |=>
		$stable(write_index_reg) && occ_reg == TSF_FULL_CNT) else $error("drop changed queue");
	a_roll_overwrites: assert property (push && full_eff && overwrite_when_full_reg && !flush
		&& !REG_WR_I |=> write_index_reg == $past(write_index_reg) + TSF_IDX_ONE &&
		read_index_reg == $past(read_index_reg) + TSF_IDX_ONE) else $error("overwrite wrong");
	a_high_byte_first: assert property (pop_rd && phase_reg == TSF_HIGH_BYTE |=>
		REG_RDATA_O == $past(queue_mem[read_index_reg][TSF_WORD_W-1:TSF_BYTE_W]))
		else $error("high byte not first");
	a_occ_bounded: assert property (occ_reg <= TSF_FULL_CNT) else $error("occupancy over depth");
	a_flag_type_low: assert property (push && !flush && !afull_type_reg && cond_next |=>
		a_full_reg) else $error("flag not set by sample");
	a_flag_keeps_data: assert property (a_full_reg && pop_rd && !pop_clears_flag_reg |=>
		a_full_reg) else $error("data read cleared flag");
	a_irq_pin_level: assert property (a_full_reg && AFULL_IRQ_EN_I && PIN_ZERO_FUNCTION_I ==
		TSF_PIN_IRQ_MODE |=> GENERAL_PIN_ZERO_IRQ_O) else $error("pin interrupt missing");
	a_flag_fresh_only: assert property (push && !flush && afull_type_reg && cond_reg && !a_full_reg |=>
		!a_full_reg) else $error("flag set without fresh entry");
	a_data_read_clears: assert property (pop_rd && pop_clears_flag_reg |=>
		!a_full_reg) else $error("data read left flag set");
	a_rd_index_write: assert property (REG_WR_I && REG_ADDR_I == TSF_ADDR_RD_IDX |=>
		read_index_reg == $past(REG_WDATA_I[TSF_IDX_W-1:0])) else $error("read index write lost");

	c_rollover: cover property (push && full_eff && overwrite_when_full_reg);
	c_flag_set: cover property (!a_full_reg ##1 a_full_reg);
	c_flush_full: cover property (flush && occ_reg != '0);
	c_word_popped: cover property (pop_rd ##1 pop_adv);
	c_fresh_hold: cover property (push && afull_type_reg && cond_reg && !a_full_reg);
endmodule : tsf_sample_queue

// file: test/tsf_master_model.sv
`timescale 1ns/1ps
// ************************************************
// register bus master stand-in
// ************************************************
module tsf_master_model (
	input wire logic clk_i,
	input wire logic [7:0] rdata_i,
	output logic [7:0] addr_o,
	output logic rd_o,
	output logic wr_o,
	output logic [7:0] wdata_o
);
	import tsf_pkg::*;
	// idle bus from time zero
	initial begin
		addr_o = 8'hff;
		rd_o = 1'b0;
		wr_o = 1'b0;
		wdata_o = 8'h00;
	end
	// one byte read, data lands on the taking edge
	task automatic rd_byte(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i);
		#1 addr_o = a;
		rd_o = 1'b1;
		@(posedge clk_i);
		#1 d = rdata_i;
		rd_o = 1'b0;
		addr_o = ~a;
	endtask : rd_byte
	// one byte write, released address and data are inverted
	task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		#1 addr_o = a;
		wdata_o = d;
		wr_o = 1'b1;
		@(posedge clk_i);
		#1 wr_o = 1'b0;
		addr_o = ~a;
		wdata_o = ~d;
	endtask : wr_byte
	// back-to-back burst of two data bytes, high byte first
	task automatic pop_word(output logic [15:0] w);
		@(posedge clk_i);
		#1 addr_o = TSF_ADDR_POP;
		rd_o = 1'b1;
		@(posedge clk_i);
		#1 w[15:8] = rdata_i;
		@(posedge clk_i);
		#1 w[7:0] = rdata_i;
		rd_o = 1'b0;
		addr_o = ~TSF_ADDR_POP;
	endtask : pop_word
	// lost count read first, then both ways of counting words
	task automatic avail(output int by_cnt, output int by_idx);
		logic [7:0] l, o, wi, ri;
		rd_byte(TSF_ADDR_LOST, l);
		rd_byte(TSF_ADDR_OCC, o);
		rd_byte(TSF_ADDR_WR_IDX, wi);
		rd_byte(TSF_ADDR_RD_IDX, ri);
		by_cnt = (l == 8'h00) ? int'(o) : 32;
		by_idx = (l == 8'h00) ? int'((wi - ri) & 8'h1f) : 32;
	endtask : avail
endmodule : tsf_master_model

// file: test/tsf_sample_queue_tb.sv
`timescale 1ns/1ps
// ************************************************
// sample queue bench
// ************************************************
module tsf_sample_queue_tb;
	import tsf_pkg::*;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic sv = 1'b0;
	logic [15:0] sd = 16'h0000;
	logic sr, rd, wr, flag, irq;
	logic [7:0] addr, wd, rdat, b;
	logic en = 1'b0;
	logic [1:0] mode = 2'h0;
	logic [15:0] mem [32];
	logic [15:0] w;
	logic [31:0] seed = 32'hde14_19ae;
	int wp, rp, oc, lost, roll, errors, total_checks, n, n2;
	// clock, 50 ns period
	always #25 clk = ~clk;
	// design and bus master
	tsf_sample_queue dut_u (.SYS_CLK_I(clk), .RST_B_I(rst_b), .SAMPLE_VALID_I(sv), .SAMPLE_DATA_I(sd),
		.SAMPLE_READY_O(sr), .REG_ADDR_I(addr), .REG_RD_I(rd), .REG_WR_I(wr), .REG_WDATA_I(wd),
		.REG_RDATA_O(rdat), .AFULL_IRQ_EN_I(en), .PIN_ZERO_FUNCTION_I(mode), .AFULL_FLAG_O(flag),
		.GENERAL_PIN_ZERO_IRQ_O(irq));
	tsf_master_model m_u (.clk_i(clk), .rdata_i(rdat), .addr_o(addr), .rd_o(rd), .wr_o(wr), .wdata_o(wd));
	// xorshift source of sample words
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xs
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		total_checks = total_checks + 1;
		if (seen !== exp) begin
			errors = errors + 1;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic give_verdict();
		if (errors == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : give_verdict
	// expected queue: full drops or overwrites, lost saturates
	task automatic m_push(input logic [15:0] v);
		if (oc == 32) begin
			lost = (lost == 31) ? 31 : lost + 1;
			if (roll != 0) begin
				mem[wp] = v;
				wp = (wp + 1) % 32;
				rp = (rp + 1) % 32;
			end
		end else begin
			mem[wp] = v;
			wp = (wp + 1) % 32;
			oc = oc + 1;
		end
	endtask : m_push
	// offer random samples under the valid/ready handshake
	task automatic push_n(input int k);
		for (int i = 0; i < k; i++) begin
			seed = xs(seed);
			@(posedge clk);
			#1 sv = 1'b1;
			sd = seed[15:0];
			// ready stands between edges; the next edge takes the word
			while (sr !== 1'b1) begin
				@(posedge clk);
				#1;
			end
			@(posedge clk);
			#1 sv = 1'b0;
			sd = ~seed[15:0];
			m_push(seed[15:0]);
		end
		repeat (4) @(posedge clk);
		#1;
	endtask : push_n
	task automatic pop_chk();
		m_u.pop_word(w);
		chk("word", w, mem[rp]);
		rp = (rp + 1) % 32;
		oc = (oc > 0) ? oc - 1 : 0;
		lost = 0;
	endtask : pop_chk
	task automatic regs_chk();
		m_u.rd_byte(TSF_ADDR_WR_IDX, b);
		chk("write_index", 16'(b), 16'(wp));
		m_u.rd_byte(TSF_ADDR_RD_IDX, b);
		chk("read_index", 16'(b), 16'(rp));
		m_u.rd_byte(TSF_ADDR_LOST, b);
		chk("lost_word_counter", 16'(b), 16'(lost));
		m_u.rd_byte(TSF_ADDR_OCC, b);
		chk("occupancy", 16'(b), 16'(oc));
	endtask : regs_chk
	task automatic stat_chk(input logic [15:0] exp);
		m_u.rd_byte(TSF_ADDR_STATUS, b);
		chk("status_flag", 16'(b[7]), exp);
	endtask : stat_chk
	// flush with new policy bits, flush bit reads back zero
	task automatic flush(input logic [7:0] pol);
		m_u.wr_byte(TSF_ADDR_POLICY, 8'h10 | pol);
		roll = pol[1];
		wp = 0;
		rp = 0;
		oc = 0;
		lost = 0;
		m_u.rd_byte(TSF_ADDR_POLICY, b);
		chk("policy", 16'(b), 16'(pol));
		regs_chk();
	endtask : flush
	// main sequence
	initial begin
		repeat (16) @(posedge clk);
		chk("ready_in_reset", 16'(sr), 16'h0000);
		#1 rst_b = 1'b1;
		repeat (2) @(posedge clk);
		#1 chk("ready_after_reset", 16'(sr), 16'h0001);
		chk("flag_after_reset", 16'(flag), 16'h0000);
		regs_chk();
		m_u.wr_byte(TSF_ADDR_WR_IDX, 8'h15);
		m_u.rd_byte(8'h30, b);
		chk("unmapped", 16'(b), 16'h0000);
		push_n(5);
		pop_chk();
		pop_chk();
		regs_chk();
		m_u.avail(n, n2);
		chk("avail_cnt", 16'(n), 16'(oc));
		chk("avail_idx", 16'(n2), 16'(oc));
		m_u.wr_byte(TSF_ADDR_RD_IDX, 8'h00);
		rp = 0;
		pop_chk();
		flush(8'h00);
		push_n(34);
		regs_chk();
		m_u.avail(n, n2);
		chk("avail_full", 16'(n), 16'h0020);
		chk("avail_full_idx", 16'(n2), 16'h0020);
		pop_chk();
		regs_chk();
		flush(8'h02);
		push_n(65);
		regs_chk();
		pop_chk();
		flush(8'h00);
		// flag left set by the full phases; pops and flush kept it
		stat_chk(16'h0001);
		m_u.wr_byte(TSF_ADDR_WMARK, 8'h02);
		m_u.rd_byte(TSF_ADDR_WMARK, b);
		chk("watermark", 16'(b), 16'h0002);
		push_n(29);
		chk("flag_29", 16'(flag), 16'h0000);
		push_n(1);
		chk("flag_30", 16'(flag), 16'h0001);
		en = 1'b1;
		mode = TSF_PIN_IRQ_MODE;
		repeat (3) @(posedge clk);
		#1 chk("pin_on", 16'(irq), 16'h0001);
		mode = 2'h2;
		repeat (3) @(posedge clk);
		#1 chk("pin_mode2", 16'(irq), 16'h0000);
		mode = TSF_PIN_IRQ_MODE;
		en = 1'b0;
		repeat (3) @(posedge clk);
		#1 chk("pin_no_en", 16'(irq), 16'h0000);
		pop_chk();
		chk("flag_pop", 16'(flag), 16'h0001);
		stat_chk(16'h0001);
		chk("flag_clr", 16'(flag), 16'h0000);
		push_n(1);
		stat_chk(16'h0001);
		push_n(1);
		chk("flag_again", 16'(flag), 16'h0001);
		stat_chk(16'h0001);
		m_u.wr_byte(TSF_ADDR_POLICY, 8'h04);
		push_n(1);
		chk("flag_type", 16'(flag), 16'h0000);
		flush(8'h08);
		push_n(30);
		chk("flag_set", 16'(flag), 16'h0001);
		pop_chk();
		chk("flag_datard", 16'(flag), 16'h0000);
		give_verdict();
	end
	// watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge clk);
		errors = errors + 1;
		give_verdict();
	end
endmodule : tsf_sample_queue_tb
